// file: defect_list_regs.svh
// Constants for the defect list sector reader
`ifndef DEFECT_LIST_REGS_SVH
`define DEFECT_LIST_REGS_SVH
`define ADDR_CTRL        4'h0
`define ADDR_TARGET      4'h1
`define ADDR_STATUS      4'h2
`define ADDR_COUNT       4'h3
`define ADDR_DATE_LO     4'h4
`define ADDR_DATE_HI     4'h5
`define ADDR_ENTRY_HI    4'h6
`define ADDR_ENTRY_LO    4'h7
`define CTRL_START_BIT   0
`define CTRL_NOSPLICE_BIT 1
`define SYNC_BYTE        8'hfe
`define FILL_BYTE        8'hff
`define PAD_BYTE         8'h00
`define FLAG_RSVD_MASK   8'hfc
`define SIZE_256         2'b00
`define SIZE_512         2'b01
`define LEN_256          10'h100
`define LEN_512          10'h200
`define MAX_ENT_256      7'h32
`define MAX_ENT_512      7'h65
`define CYL_FIXED        16'h0fff
`define CYL_MINUS        16'h0008
`define DATE_LEN         4'h6
`define ENTRY_LEN        3'h5
`define HDR_LEN          3'h5
`define CRC_POLY         16'h1021
`define CRC_SEED         16'h0000
`define MONTH_MIN        8'h01
`define MONTH_MAX        8'h0c
`define DAY_MAX          8'h1f
`define YEAR_MIN         8'h52
`endif

// file: defect_list_pkg.sv
// Types shared by the defect list reader
package defect_list_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_HSYNC, ST_HDR, ST_HCRC, ST_DSYNC, ST_DATE, ST_ENTRY,
    ST_FILL, ST_DCRC, ST_DONE
  } rd_state_t;
  typedef struct packed {
    logic [15:0] cylinder;
    logic [15:0] byte_offset;
    logic [7:0]  length;
  } entry_t;
endpackage : defect_list_pkg

// file: crc16_ccitt.sv
// Bytewise CRC-16 with polynomial x^16+x^12+x^5+1, zero seed
`timescale 1ns/1ps
`include "defect_list_regs.svh"
module crc16_ccitt (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Control
  input  wire logic        clear,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_in,
  // Result
  output logic      [15:0] crc
);
  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ `CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction : crc_step

  assign crc_next = clear ? `CRC_SEED :
                    (byte_valid ? crc_step(crc_reg, byte_in) : crc_reg);
  assign crc = crc_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      crc_reg <= `CRC_SEED;
    end else begin
      crc_reg <= crc_next;
    end
  end
endmodule : crc16_ccitt

// file: byte_assembler.sv
// Deserialises read data, MSB first, into bytes after sync
`timescale 1ns/1ps
`include "defect_list_regs.svh"
module byte_assembler (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Serial side
  input  wire logic       hunt,
  input  wire logic       bit_valid,
  input  wire logic       bit_in,
  // Byte side
  output logic            sync_found,
  output logic            byte_valid,
  output logic      [7:0] byte_out
);
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] cnt_reg;
  logic       framed_reg;
  logic       byte_valid_reg;
  logic [7:0] byte_reg;
  wire        sync_hit;
  wire        byte_done;

  assign shift_next = {shift_reg[6:0], bit_in};
  assign sync_hit   = hunt && bit_valid && shift_next == `SYNC_BYTE;
  assign byte_done  = !hunt && framed_reg && bit_valid && cnt_reg == 3'h7;
  assign sync_found = byte_valid_reg && hunt;
  assign byte_valid = byte_valid_reg;
  assign byte_out   = byte_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shift_reg      <= 8'h00;
      cnt_reg        <= 3'h0;
      framed_reg     <= 1'b0;
      byte_valid_reg <= 1'b0;
      byte_reg       <= 8'h00;
    end else begin
      byte_valid_reg <= sync_hit || byte_done;
      if (bit_valid) begin
        shift_reg <= shift_next;
        cnt_reg   <= (sync_hit || !framed_reg) ? 3'h0 : cnt_reg + 3'h1;
      end
      if (sync_hit) begin
        framed_reg <= 1'b1;
        byte_reg   <= shift_next;
      end else if (hunt && !byte_valid_reg) begin
        // Keep framing through the sync byte's own valid cycle
        framed_reg <= 1'b0;
      end
      if (byte_done) begin
        byte_reg  <= shift_next;
        // Stale bits must not fake a sync at the next hunt
        shift_reg <= 8'h00;
      end
    end
  end
endmodule : byte_assembler

// file: defect_list_reader.sv
// Controller that reads and parses a drive's defect list sector
`timescale 1ns/1ps
`include "defect_list_regs.svh"
module defect_list_reader
  import defect_list_pkg::*;
#(
  parameter int MAX_CYL_W = 16
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Software register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // Drive read path
  input  wire logic        read_clock_tick,
  input  wire logic        read_data,
  output logic             read_gate,
  output logic             zone0_select,
  // Decoded entry stream
  output logic             entry_valid,
  output entry_t           entry_data
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  rd_state_t   state_reg, state_next;
  logic [15:0] max_cyl_reg;
  logic [1:0]  which_cyl_reg;
  logic [7:0]  head_reg;
  logic        nosplice_reg;
  logic        busy_reg;
  logic        hdr_err_reg, crc_err_reg, hcrc_err_reg, full_reg, done_reg;
  logic        date_err_reg;
  logic [9:0]  pos_reg;
  logic [9:0]  size_reg;
  logic [6:0]  count_reg;
  logic [6:0]  max_ent_reg;
  logic [47:0] date_reg;
  logic [39:0] acc_reg;
  logic [2:0]  sub_reg;
  logic        entry_valid_reg;
  entry_t      entry_reg;
  logic [15:0] hdr_cyl_reg;
  logic [31:0] rdata_reg;
  logic [15:0] crc_hold_reg;

  // ------------------------------------------------------------
  // Byte path and CRC
  // ------------------------------------------------------------
  wire        hunt = state_reg == ST_HSYNC || state_reg == ST_DSYNC;
  wire        sync_found;
  wire        bvalid;
  wire [7:0]  bdata;
  wire [15:0] crc;
  wire        crc_clear = state_reg == ST_IDLE || state_reg == ST_HCRC &&
                          bvalid && pos_reg == 10'h1;

  byte_assembler u_bytes (
    .clock      (clock),
    .reset_n    (reset_n),
    .hunt       (hunt),
    .bit_valid  (read_clock_tick),
    .bit_in     (read_data),
    .sync_found (sync_found),
    .byte_valid (bvalid),
    .byte_out   (bdata)
  );

  crc16_ccitt u_crc (
    .clock      (clock),
    .reset_n    (reset_n),
    .clear      (crc_clear),
    .byte_valid (bvalid),
    .byte_in    (bdata),
    .crc        (crc)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire start_wr = reg_write && reg_addr == `ADDR_CTRL &&
                  reg_wdata[`CTRL_START_BIT];
  wire [15:0] target_cyl = which_cyl_reg == 2'h0 ? max_cyl_reg :
                           which_cyl_reg == 2'h1 ?
                           max_cyl_reg - `CYL_MINUS : `CYL_FIXED;
  wire flag_bad  = (bdata & `FLAG_RSVD_MASK) != 8'h00 ||
                   bdata[1:0] > `SIZE_512;
  wire [9:0] flag_size = bdata[1:0] == `SIZE_512 ?
                         `LEN_512 : `LEN_256;
  wire [6:0] flag_max  = bdata[1:0] == `SIZE_512 ?
                         `MAX_ENT_512 : `MAX_ENT_256;
  // Field size counts the date record, which pos_reg skips
  wire end_of_field = pos_reg ==
                      size_reg - {6'h0, `DATE_LEN} - 10'h1;
  wire [39:0] acc_next = {acc_reg[31:0], bdata};
  wire all_ff = acc_next == {5{`FILL_BYTE}};
  // Computed check word against the two received check bytes
  wire crc_match = crc_hold_reg == {acc_reg[7:0], bdata};
  wire date_bad = date_reg[47:40] < `MONTH_MIN ||
                  date_reg[47:40] > `MONTH_MAX ||
                  date_reg[39:32] > `DAY_MAX ||
                  date_reg[31:24] < `YEAR_MIN;

  // ------------------------------------------------------------
  // State machine
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (start_wr) state_next = ST_HSYNC;
      ST_HSYNC: if (sync_found) state_next = ST_HDR;
      ST_HDR:   if (bvalid && pos_reg == {7'h0, `HDR_LEN} - 10'h1)
                  state_next = ST_HCRC;
      ST_HCRC:  if (bvalid && pos_reg == 10'h1) state_next = ST_DSYNC;
      ST_DSYNC: if (sync_found) state_next = ST_DATE;
      ST_DATE:  if (bvalid && pos_reg == {6'h0, `DATE_LEN} - 10'h1)
                  state_next = ST_ENTRY;
      ST_ENTRY: if (bvalid && end_of_field) state_next = ST_DCRC;
                else if (bvalid && sub_reg == `ENTRY_LEN - 3'h1 &&
                         (all_ff || count_reg == max_ent_reg))
                  state_next = ST_FILL;
      ST_FILL:  if (bvalid && end_of_field) state_next = ST_DCRC;
      ST_DCRC:  if (bvalid && pos_reg == 10'h1) state_next = ST_DONE;
      ST_DONE:  state_next = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      pos_reg <= 10'h0;
      sub_reg <= 3'h0;
      acc_reg <= 40'h0;
    end else begin
      state_reg <= state_next;
      // Fill keeps counting toward the end of the field
      if (state_next != state_reg && state_next != ST_FILL) begin
        pos_reg <= 10'h0;
        sub_reg <= 3'h0;
      end else if (bvalid) begin
        pos_reg <= pos_reg + 10'h1;
        sub_reg <= sub_reg == `ENTRY_LEN - 3'h1 ? 3'h0 : sub_reg + 3'h1;
      end
      if (bvalid) acc_reg <= acc_next;
    end
  end

  // ------------------------------------------------------------
  // Parse results
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      size_reg <= `LEN_256;
      max_ent_reg <= `MAX_ENT_256;
      hdr_err_reg <= 1'b0;
      hcrc_err_reg <= 1'b0;
      crc_err_reg <= 1'b0;
      full_reg <= 1'b0;
      date_err_reg <= 1'b0;
      count_reg <= 7'h0;
      date_reg <= 48'h0;
      hdr_cyl_reg <= 16'h0;
      crc_hold_reg <= 16'h0;
      entry_valid_reg <= 1'b0;
      entry_reg <= '0;
    end else begin
      entry_valid_reg <= 1'b0;
      if (state_reg == ST_IDLE && start_wr) begin
        hdr_err_reg <= 1'b0;
        hcrc_err_reg <= 1'b0;
        crc_err_reg <= 1'b0;
        full_reg <= 1'b0;
        date_err_reg <= 1'b0;
        count_reg <= 7'h0;
      end
      if (state_reg == ST_HDR && bvalid) begin
        unique case (pos_reg[2:0])
          3'h0: hdr_cyl_reg[15:8] <= bdata;
          3'h1: hdr_cyl_reg[7:0] <= bdata;
          3'h2: if (bdata != head_reg) hdr_err_reg <= 1'b1;
          3'h3: if (bdata != 8'h00) hdr_err_reg <= 1'b1;
          default: begin
            if (flag_bad || hdr_cyl_reg != target_cyl) hdr_err_reg <= 1'b1;
            size_reg <= flag_size;
            max_ent_reg <= flag_max;
          end
        endcase
      end
      if ((state_reg == ST_HCRC || state_reg == ST_DCRC) && bvalid &&
          pos_reg == 10'h0) begin
        crc_hold_reg <= crc;
      end
      if (state_reg == ST_HCRC && state_next == ST_DSYNC &&
          !crc_match) begin
        hcrc_err_reg <= 1'b1;
      end
      if (state_reg == ST_DCRC && state_next == ST_DONE &&
          !crc_match) begin
        crc_err_reg <= 1'b1;
      end
      if (state_reg == ST_DCRC) begin
        date_err_reg <= date_bad;
      end
      if (state_reg == ST_DATE && bvalid) begin
        date_reg <= {date_reg[39:0], bdata};
      end
      if (state_reg == ST_ENTRY && bvalid && sub_reg == `ENTRY_LEN - 3'h1 &&
          !all_ff) begin
        if (count_reg == max_ent_reg) begin
          full_reg <= 1'b1;
        end else begin
          entry_valid_reg <= 1'b1;
          entry_reg <= acc_next;
          count_reg <= count_reg + 7'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  wire done_set = state_reg == ST_DONE;
  wire [31:0] status_word = {24'h0, date_err_reg, full_reg, crc_err_reg,
                             hcrc_err_reg, hdr_err_reg, 1'b0, done_reg,
                             busy_reg};
  wire [31:0] rd_mux =
    reg_addr == `ADDR_CTRL    ? {30'h0, nosplice_reg, 1'b0} :
    reg_addr == `ADDR_TARGET  ? {6'h0, which_cyl_reg, head_reg, max_cyl_reg} :
    reg_addr == `ADDR_STATUS  ? status_word :
    reg_addr == `ADDR_COUNT   ? {6'h0, size_reg, 9'h0, count_reg} :
    reg_addr == `ADDR_DATE_LO ? date_reg[31:0] :
    reg_addr == `ADDR_DATE_HI ? {16'h0, date_reg[47:32]} :
    reg_addr == `ADDR_ENTRY_HI ? {24'h0, entry_reg.length} :
    reg_addr == `ADDR_ENTRY_LO ? {entry_reg.cylinder, entry_reg.byte_offset} :
    32'h0;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      max_cyl_reg <= 16'h0;
      which_cyl_reg <= 2'h0;
      head_reg <= 8'h0;
      nosplice_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      if (reg_write && reg_addr == `ADDR_TARGET && state_reg == ST_IDLE) begin
        max_cyl_reg <= reg_wdata[15:0];
        head_reg <= reg_wdata[23:16];
        which_cyl_reg <= reg_wdata[25:24];
      end
      if (reg_write && reg_addr == `ADDR_CTRL && state_reg == ST_IDLE) begin
        nosplice_reg <= reg_wdata[`CTRL_NOSPLICE_BIT];
      end
      busy_reg <= state_next != ST_IDLE;
      if (done_set) begin
        done_reg <= 1'b1;
      end else if (reg_read && reg_addr == `ADDR_STATUS) begin
        done_reg <= 1'b0;
      end
      rdata_reg <= reg_read ? rd_mux : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign read_gate = state_reg != ST_IDLE && state_reg != ST_DONE;
  assign zone0_select = busy_reg;
  assign entry_valid = entry_valid_reg;
  assign entry_data = entry_reg;
endmodule : defect_list_reader

// file: defect_list_reader_asserts.sv
// Port checks for the defect list reader
`timescale 1ns/1ps
`include "defect_list_regs.svh"
module defect_list_reader_asserts
  import defect_list_pkg::*;
#(
  parameter int MAX_CYL_W = 16
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Register port
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  // Drive and entries
  input wire logic        read_clock_tick,
  input wire logic        read_data,
  input wire logic        read_gate,
  input wire logic        zone0_select,
  input wire logic        entry_valid,
  input wire entry_t      entry_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] seen_reg;
  always_ff @(posedge clock) begin
    if (!reset_n || !zone0_select) seen_reg <= 8'h00;
    else if (entry_valid) seen_reg <= seen_reg + 8'h01;
  end
  sequence s_start;
    reg_write && reg_addr == `ADDR_CTRL && reg_wdata[0] && !zone0_select;
  endsequence
  property p_start_gate;
    s_start |-> ##[1:3] (read_gate && zone0_select);
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("gate");
  property p_zone_gate;
    read_gate |-> zone0_select;
  endproperty
  a_zone_gate: assert property (p_zone_gate) else $error("zone");
  property p_pulse;
    entry_valid |=> !entry_valid [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("entry pulse");
  property p_in_read;
    entry_valid |-> zone0_select;
  endproperty
  a_in_read: assert property (p_in_read) else $error("stray");
  property p_hold;
    !entry_valid |-> $stable(entry_data);
  endproperty
  a_hold: assert property (p_hold) else $error("entry moved");
  property p_tick;
    entry_valid |-> $past(read_clock_tick, 2);
  endproperty
  a_tick: assert property (p_tick) else $error("entry timing");
  property p_rdata_zero;
    !reg_read |=> reg_rdata == 32'h0;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("data");
  property p_limit;
    seen_reg <= 8'h65;
  endproperty
  a_limit: assert property (p_limit) else $error("too many");
endmodule : defect_list_reader_asserts

bind defect_list_reader defect_list_reader_asserts #(.MAX_CYL_W(MAX_CYL_W))
  u_chk (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .read_clock_tick(read_clock_tick),
  .read_data(read_data), .read_gate(read_gate),
  .zone0_select(zone0_select), .entry_valid(entry_valid),
  .entry_data(entry_data));

// file: drive_model.sv
// Drive that plays back a recorded defect list sector
`timescale 1ns/1ps
module drive_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Sector contents
  input  wire logic [6:0]  n_ent,
  input  wire logic [7:0]  flag,
  input  wire logic        bad_crc,
  input  wire logic [15:0] hdr_cyl,
  // Read path
  input  wire logic        read_gate,
  input  wire logic        zone0_select,
  output logic             read_clock_tick,
  output logic             read_data
);
  logic        bq[$];
  logic [15:0] crc;
  logic        busy_reg;
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bq.push_back(b[i]);
  endtask : put
  task automatic addc(input logic [7:0] b);
    put(b);
    for (int i = 7; i >= 0; i--)
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? 16'h1021 : 16'h0);
  endtask : addc
  task automatic build();
    int size;
    int cnt;
    bq.delete();
    size = (flag[1:0] == 2'b01) ? 512 : 256;
    put(8'h00);
    crc = 16'h0;
    addc(8'hfe);
    addc(hdr_cyl[15:8]);
    addc(hdr_cyl[7:0]);
    addc(8'h02);
    addc(8'h00);
    addc(flag);
    put(crc[15:8]);
    put(crc[7:0]);
    put(8'h00);
    crc = 16'h0;
    addc(8'hfe);
    addc(8'h07);
    addc(8'h15);
    addc(8'h5a);
    addc(8'h02);
    addc(8'h00);
    addc(8'h00);
    cnt = 6;
    for (int k = 0; k < n_ent; k++) begin
      addc(8'h03);
      addc(8'(k));
      addc(8'h0a);
      addc(8'(k));
      addc(8'(k + 1));
      cnt += 5;
    end
    while (cnt < size) begin
      addc(8'hff);
      cnt++;
    end
    crc = crc ^ {15'h0, bad_crc};
    put(crc[15:8]);
    put(crc[7:0]);
  endtask : build
  // Plays only while zone 0 is selected; garbage between bits
  always @(posedge clock) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
      read_clock_tick <= 1'b0;
      read_data <= 1'b0;
    end else begin
      if (!read_gate) busy_reg <= 1'b0;
      else if (!busy_reg && zone0_select) begin
        build();
        busy_reg <= 1'b1;
      end
      if (busy_reg && read_gate && !read_clock_tick && bq.size() > 0) begin
        read_clock_tick <= 1'b1;
        read_data <= bq.pop_front();
      end else begin
        read_clock_tick <= 1'b0;
        read_data <= ~read_data;
      end
    end
  end
endmodule : drive_model

// file: defect_list_reader_bench.sv
// Self-checking bench for the defect list reader
`timescale 1ns/1ps
`include "defect_list_regs.svh"
module defect_list_reader_bench;
  import defect_list_pkg::*;
  logic        clock, reset_n, reg_write, reg_read, bad_crc;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, s;
  logic        read_clock_tick, read_data, read_gate, zone0_select;
  logic        entry_valid;
  entry_t      entry_data;
  logic [6:0]  n_ent;
  logic [7:0]  flag;
  logic [15:0] hdr_cyl;
  int          fails, cmp_count, seen;
  defect_list_reader i_dut (.clock(clock), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .read_clock_tick(read_clock_tick), .read_data(read_data),
    .read_gate(read_gate), .zone0_select(zone0_select),
    .entry_valid(entry_valid), .entry_data(entry_data));
  drive_model i_drive (.clock(clock), .reset_n(reset_n), .n_ent(n_ent),
    .flag(flag), .bad_crc(bad_crc), .hdr_cyl(hdr_cyl),
    .read_gate(read_gate), .zone0_select(zone0_select),
    .read_clock_tick(read_clock_tick), .read_data(read_data));
  always #5 clock = ~clock;
  always @(posedge clock) if (entry_valid === 1'b1) seen <= seen + 1;
  task automatic print_verdict();
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic run(input logic [6:0] n, input logic [7:0] f, input logic b,
                     input logic [1:0] sel, input logic [15:0] hc,
                     input logic [7:0] err);
    logic [31:0] r;
    logic [7:0]  k;
    logic [9:0]  sz;
    k = {1'b0, n - 7'h1};
    sz = (f[1:0] == `SIZE_512) ? `LEN_512 : `LEN_256;
    n_ent <= n;
    flag <= f;
    bad_crc <= b;
    hdr_cyl <= hc;
    seen = 0;
    wr(`ADDR_TARGET, {6'h00, sel, 8'h02, 16'h0400});
    wr(`ADDR_CTRL, 32'h1);
    r = 32'h0;
    for (int i = 0; i < 12000 && r[1] !== 1'b1; i++) rd(`ADDR_STATUS, r);
    if (r[1] !== 1'b1) begin
      fails++;
      print_verdict();
    end
    check("errors", r & 32'hf8, {24'h0, err});
    check("entries", 32'(seen), {25'h0, n});
    check("entry", entry_data[39:8], {8'h03, k, 8'h0a, k});
    check("length", 32'(entry_data.length), {25'h0, n});
    rd(`ADDR_COUNT, r);
    check("count", r & 32'h03ff007f, {6'h0, sz, 9'h0, n});
    rd(`ADDR_ENTRY_LO, r);
    check("entry reg", r, {8'h03, k, 8'h0a, k});
    rd(`ADDR_DATE_HI, r);
    check("date hi", r, 32'h00000715);
    rd(`ADDR_DATE_LO, r);
    check("date lo", r, 32'h5a020000);
  endtask : run
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    {reg_write, reg_read, bad_crc} = 3'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    {n_ent, flag, hdr_cyl} = 31'h0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(4'hf, s);
    check("unmapped", s, 32'h0);
    rd(`ADDR_STATUS, s);
    check("idle status", s, 32'h0);
    run(7'h03, 8'h00, 1'b0, 2'h0, 16'h0400, 8'h00);
    run(7'h32, 8'h00, 1'b0, 2'h1, 16'h03f8, 8'h00);
    run(7'h65, 8'h01, 1'b0, 2'h2, 16'h0fff, 8'h00);
    run(7'h02, 8'h00, 1'b1, 2'h0, 16'h0400, 8'h20);
    run(7'h02, 8'h05, 1'b0, 2'h0, 16'h0400, 8'h08);
    run(7'h02, 8'h02, 1'b0, 2'h0, 16'h0400, 8'h08);
    run(7'h02, 8'h00, 1'b0, 2'h0, 16'h03f8, 8'h08);
    rd(`ADDR_STATUS, s);
    check("done cleared", s & 32'h3, 32'h0);
    print_verdict();
  end
endmodule : defect_list_reader_bench
